// *** common/fcs_consts.vh ***
// Constants for the flash command sequencer host controller
`ifndef FCS_CONSTS_VH
`define FCS_CONSTS_VH

// ****************************************************************
// Timing
// ****************************************************************
`define FCS_CLK_MHZ        40
`define FCS_T_AS_NS        25
`define FCS_T_WP_NS        35
`define FCS_T_WPH_NS       30
`define FCS_T_ACC_NS       120
`define FCS_T_RP_NS        500
`define FCS_T_RH_NS        50
// Cycle counts are the ns figures rounded up at the clock rate; keep them in step
`define FCS_T_AS_CYC       5'h01
`define FCS_T_WP_CYC       5'h02
`define FCS_T_WPH_CYC      5'h02
`define FCS_T_ACC_CYC      5'h05
`define FCS_T_RP_CYC       5'h14
`define FCS_T_RH_CYC       5'h02

// ****************************************************************
// Flash command codes and unlock addresses
// ****************************************************************
`define FCS_UNLOCK1_ADDR_W 18'h00555
`define FCS_UNLOCK2_ADDR_W 18'h002aa
`define FCS_UNLOCK1_ADDR_B 18'h00aaa
`define FCS_UNLOCK2_ADDR_B 18'h00555
`define FCS_UNLOCK1_DATA   16'h00aa
`define FCS_UNLOCK2_DATA   16'h0055
`define FCS_CMD_AUTOSEL    16'h0090
`define FCS_CMD_PROG       16'h00a0
`define FCS_CMD_ERASE_SET  16'h0080
`define FCS_CMD_CHIP_ERASE 16'h0010
`define FCS_CMD_RESET      16'h00f0

// ****************************************************************
// Status bits on the flash data bus
// ****************************************************************
`define FCS_DQ_POLL        7
`define FCS_DQ_TOGGLE      6
`define FCS_DQ_TIMEOUT     5

// ****************************************************************
// Register map, byte offsets
// ****************************************************************
`define FCS_REG_CTRL       5'h00
`define FCS_REG_ADDR       5'h04
`define FCS_REG_WDATA      5'h08
`define FCS_REG_RDATA      5'h0c
`define FCS_REG_STATUS     5'h10

// Control fields
`define FCS_CTRL_OP        2:0
`define FCS_CTRL_BYTE      3

// Operation codes
`define FCS_OP_NONE        3'h0
`define FCS_OP_READ        3'h1
`define FCS_OP_PROG        3'h2
`define FCS_OP_ERASE       3'h3
`define FCS_OP_AUTOSEL     3'h4
`define FCS_OP_RESET       3'h5
`define FCS_OP_HWRESET     3'h6

// Sequence lengths, last step index
`define FCS_LAST_PROG      3'd3
`define FCS_LAST_ERASE     3'd5
`define FCS_LAST_AUTOSEL   3'd3
`define FCS_LAST_SINGLE    3'd0

// Status fields
`define FCS_ST_BUSY        0
`define FCS_ST_DONE        1
`define FCS_ST_ERR         2
`define FCS_ST_RB          3
`define FCS_ST_AUTOSEL     4
`define FCS_ST_VERIFY      5

`endif

// *** rtl/fcs_bus_cycle.v ***
// One asynchronous flash bus cycle, read or write, from clocked timing
`timescale 1ns/10ps
`include "fcs_consts.vh"
module fcs_bus_cycle (
    input  wire        clk_sys,
    input  wire        nrst,
    input  wire        start,
    input  wire        isWrite,
    input  wire [17:0] addr,
    input  wire [15:0] wdata,
    output reg         done,
    output reg  [15:0] rdata_q,
    output reg         flashCeN,
    output reg         flashWeN,
    output reg         flashOeN,
    output reg  [17:0] flashAddr,
    output reg  [15:0] flashDqOut,
    output reg         flashDqOe,
    input  wire [15:0] flashDqIn
);
    localparam S_IDLE   = 2'd0;
    localparam S_SETUP  = 2'd1;
    localparam S_STROBE = 2'd2;
    localparam S_HOLD   = 2'd3;

    reg [1:0] state_q;
    reg [4:0] cnt_q;
    reg       wr_q;

    // ****************************************************************
    // Pin sequencer
    // ****************************************************************
    always @(posedge clk_sys) begin
        if (!nrst) begin
            state_q    <= S_IDLE;
            cnt_q      <= 5'd0;
            wr_q       <= 1'b0;
            done       <= 1'b0;
            rdata_q    <= 16'h0000;
            flashCeN   <= 1'b1;
            flashWeN   <= 1'b1;
            flashOeN   <= 1'b1;
            flashAddr  <= 18'h00000;
            flashDqOut <= 16'h0000;
            flashDqOe  <= 1'b0;
        end else begin
            done <= 1'b0;
            case (state_q)
                S_IDLE: begin
                    if (start) begin
                        wr_q       <= isWrite;
                        flashAddr  <= addr;
                        flashDqOut <= wdata;
                        flashDqOe  <= isWrite;
                        flashCeN   <= 1'b0;
                        flashOeN   <= 1'b1;
                        cnt_q      <= `FCS_T_AS_CYC;
                        state_q    <= S_SETUP;
                    end
                end
                S_SETUP: begin
                    if (cnt_q <= 5'd1) begin
                        // Strobe falls after select: address taken here
                        if (wr_q)
                            flashWeN <= 1'b0;
                        else
                            flashOeN <= 1'b0;
                        cnt_q   <= wr_q ? `FCS_T_WP_CYC : `FCS_T_ACC_CYC;
                        state_q <= S_STROBE;
                    end else begin
                        cnt_q <= cnt_q - 5'd1;
                    end
                end
                S_STROBE: begin
                    if (cnt_q <= 5'd1) begin
                        // Strobe rises first with select still low: data taken
                        flashWeN <= 1'b1;
                        flashOeN <= 1'b1;
                        if (!wr_q)
                            rdata_q <= flashDqIn;
                        cnt_q   <= `FCS_T_WPH_CYC;
                        state_q <= S_HOLD;
                    end else begin
                        cnt_q <= cnt_q - 5'd1;
                    end
                end
                S_HOLD: begin
                    flashCeN <= 1'b1;
                    if (cnt_q <= 5'd1) begin
                        flashDqOe <= 1'b0;
                        done      <= 1'b1;
                        state_q   <= S_IDLE;
                    end else begin
                        cnt_q <= cnt_q - 5'd1;
                    end
                end
                default: state_q <= S_IDLE;
            endcase
        end
    end
endmodule

// *** rtl/fcs_host_ctrl.v ***
// Host-side flash command sequencer with Avalon-MM control registers
`timescale 1ns/10ps
`include "fcs_consts.vh"
module fcs_host_ctrl (
    input  wire        clk_sys,
    input  wire        nrst,
    input  wire [4:0]  avsAddress,
    input  wire        avsRead,
    input  wire        avsWrite,
    input  wire [31:0] avsWriteData,
    input  wire [3:0]  avsByteEnable,
    output reg  [31:0] avsReadData,
    output wire        avsWaitRequest,
    output wire        flashCeN,
    output wire        flashWeN,
    output wire        flashOeN,
    output wire [17:0] flashAddr,
    output wire [15:0] flashDqOut,
    output wire        flashDqOe,
    input  wire [15:0] flashDqIn,
    output reg         flashByteModeN,
    output reg         flashResetN,
    input  wire        readyBusyIn
);
    localparam S_IDLE   = 3'd0;
    localparam S_SEQ    = 3'd1;
    localparam S_WAIT   = 3'd2;
    localparam S_POLL   = 3'd3;
    localparam S_PWAIT  = 3'd4;
    localparam S_HWRST  = 3'd5;
    localparam S_HWWAIT = 3'd6;

    reg  [2:0]  state_q;
    reg  [2:0]  curOp_q;
    reg  [2:0]  step_q;
    reg  [4:0]  cnt_q;
    reg         byteMode_q;
    reg  [17:0] addr_q;
    reg  [15:0] wdata_q;
    reg  [15:0] rdata_q;
    reg  [15:0] prev_q;
    reg         havePrev_q;
    reg         timeoutSeen_q;
    reg         busy_q;
    reg         done_q;
    reg         err_q;
    reg         verifyErr_q;
    reg         autosel_q;
    reg         ack_q;
    reg         cycStart;
    wire        cycDone;
    wire [15:0] cycRdata;
    wire        accept;
    wire        ctrlWrite;
    wire [31:0] statusWord;

    // ****************************************************************
    // Command sequence tables
    // ****************************************************************
    function [17:0] stepAddr;
        input [2:0]  op;
        input [2:0]  step;
        input        byteMode;
        input [17:0] userAddr;
        reg   [17:0] u1;
        reg   [17:0] u2;
        begin
            u1 = byteMode ? `FCS_UNLOCK1_ADDR_B : `FCS_UNLOCK1_ADDR_W;
            u2 = byteMode ? `FCS_UNLOCK2_ADDR_B : `FCS_UNLOCK2_ADDR_W;
            case (step)
                3'd0:    stepAddr = (op == `FCS_OP_READ || op == `FCS_OP_RESET) ? userAddr : u1;
                3'd1:    stepAddr = u2;
                3'd2:    stepAddr = u1;
                3'd3:    stepAddr = (op == `FCS_OP_ERASE) ? u1 : userAddr;
                3'd4:    stepAddr = u2;
                default: stepAddr = u1;
            endcase
        end
    endfunction

    function [15:0] stepData;
        input [2:0]  op;
        input [2:0]  step;
        input [15:0] userData;
        begin
            case (step)
                3'd0:    stepData = (op == `FCS_OP_RESET) ? `FCS_CMD_RESET : `FCS_UNLOCK1_DATA;
                3'd1:    stepData = `FCS_UNLOCK2_DATA;
                3'd2: begin
                    case (op)
                        `FCS_OP_PROG:  stepData = `FCS_CMD_PROG;
                        `FCS_OP_ERASE: stepData = `FCS_CMD_ERASE_SET;
                        default:       stepData = `FCS_CMD_AUTOSEL;
                    endcase
                end
                3'd3:    stepData = (op == `FCS_OP_ERASE) ? `FCS_UNLOCK1_DATA : userData;
                3'd4:    stepData = `FCS_UNLOCK2_DATA;
                default: stepData = `FCS_CMD_CHIP_ERASE;
            endcase
        end
    endfunction

    function [2:0] lastStep;
        input [2:0] op;
        begin
            case (op)
                `FCS_OP_PROG:    lastStep = `FCS_LAST_PROG;
                `FCS_OP_ERASE:   lastStep = `FCS_LAST_ERASE;
                `FCS_OP_AUTOSEL: lastStep = `FCS_LAST_AUTOSEL;
                default:         lastStep = `FCS_LAST_SINGLE;
            endcase
        end
    endfunction

    function stepIsRead;
        input [2:0] op;
        input [2:0] step;
        begin
            stepIsRead = (op == `FCS_OP_READ) || (op == `FCS_OP_AUTOSEL && step == `FCS_LAST_AUTOSEL);
        end
    endfunction

    function [31:0] mergeBytes;
        input [31:0] old;
        input [31:0] wd;
        input [3:0]  be;
        integer      i;
        begin
            mergeBytes = old;
            for (i = 0; i < 4; i = i + 1) begin
                if (be[i])
                    mergeBytes[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
    endfunction

    // ****************************************************************
    // Avalon-MM slave
    // ****************************************************************
    assign avsWaitRequest = (avsRead | avsWrite) & ~ack_q;
    assign accept         = (avsRead | avsWrite) & ack_q;
    assign ctrlWrite      = accept & avsWrite & (avsAddress == `FCS_REG_CTRL) & avsByteEnable[0];

    assign statusWord = {26'h0000000, verifyErr_q, autosel_q, readyBusyIn, err_q, done_q, busy_q};

    wire [31:0] addrMerged  = mergeBytes({14'h0000, addr_q}, avsWriteData, avsByteEnable);
    wire [31:0] wdataMerged = mergeBytes({16'h0000, wdata_q}, avsWriteData, avsByteEnable);

    always @(posedge clk_sys) begin
        if (!nrst) begin
            ack_q       <= 1'b0;
            avsReadData <= 32'h00000000;
        end else begin
            ack_q <= (avsRead | avsWrite) & ~ack_q;
            if (avsRead & ~ack_q) begin
                case (avsAddress)
                    `FCS_REG_CTRL:   avsReadData <= {28'h0000000, byteMode_q, curOp_q};
                    `FCS_REG_ADDR:   avsReadData <= {14'h0000, addr_q};
                    `FCS_REG_WDATA:  avsReadData <= {16'h0000, wdata_q};
                    `FCS_REG_RDATA:  avsReadData <= {16'h0000, rdata_q};
                    `FCS_REG_STATUS: avsReadData <= statusWord;
                    default:         avsReadData <= 32'h00000000;
                endcase
            end
        end
    end

    // ****************************************************************
    // Pin engine
    // ****************************************************************
    fcs_bus_cycle u_cycle (
        .clk_sys    (clk_sys),
        .nrst       (nrst),
        .start      (cycStart),
        .isWrite    (~((state_q == S_POLL) | stepIsRead(curOp_q, step_q))),
        .addr       (state_q == S_POLL ? addr_q : stepAddr(curOp_q, step_q, byteMode_q, addr_q)),
        .wdata      (stepData(curOp_q, step_q, wdata_q)),
        .done       (cycDone),
        .rdata_q    (cycRdata),
        .flashCeN   (flashCeN),
        .flashWeN   (flashWeN),
        .flashOeN   (flashOeN),
        .flashAddr  (flashAddr),
        .flashDqOut (flashDqOut),
        .flashDqOe  (flashDqOe),
        .flashDqIn  (flashDqIn)
    );

    always @* begin
        cycStart = (state_q == S_SEQ) || (state_q == S_POLL);
    end

    // ****************************************************************
    // Operation sequencer
    // ****************************************************************
    always @(posedge clk_sys) begin
        if (!nrst) begin
            state_q        <= S_IDLE;
            curOp_q        <= `FCS_OP_NONE;
            step_q         <= 3'd0;
            cnt_q          <= 5'd0;
            byteMode_q     <= 1'b0;
            addr_q         <= 18'h00000;
            wdata_q        <= 16'h0000;
            rdata_q        <= 16'h0000;
            prev_q         <= 16'h0000;
            havePrev_q     <= 1'b0;
            timeoutSeen_q  <= 1'b0;
            busy_q         <= 1'b0;
            done_q         <= 1'b0;
            err_q          <= 1'b0;
            verifyErr_q    <= 1'b0;
            autosel_q      <= 1'b0;
            flashByteModeN <= 1'b1;
            flashResetN    <= 1'b1;
        end else begin
            // Parameter registers only move while idle so a running sequence is stable
            if (accept && avsWrite && !busy_q) begin
                if (avsAddress == `FCS_REG_ADDR)
                    addr_q <= addrMerged[17:0];
                if (avsAddress == `FCS_REG_WDATA)
                    wdata_q <= wdataMerged[15:0];
            end
            case (state_q)
                S_IDLE: begin
                    // Start ignored while busy; software sees busy in status
                    if (ctrlWrite && avsWriteData[`FCS_CTRL_OP] != `FCS_OP_NONE) begin
                        curOp_q        <= avsWriteData[`FCS_CTRL_OP];
                        byteMode_q     <= avsWriteData[`FCS_CTRL_BYTE];
                        flashByteModeN <= ~avsWriteData[`FCS_CTRL_BYTE];
                        busy_q         <= 1'b1;
                        done_q         <= 1'b0;
                        err_q          <= 1'b0;
                        verifyErr_q    <= 1'b0;
                        step_q         <= 3'd0;
                        havePrev_q     <= 1'b0;
                        timeoutSeen_q  <= 1'b0;
                        if (avsWriteData[`FCS_CTRL_OP] == `FCS_OP_HWRESET) begin
                            flashResetN <= 1'b0;
                            cnt_q       <= `FCS_T_RP_CYC;
                            state_q     <= S_HWRST;
                        end else begin
                            state_q <= S_SEQ;
                        end
                    end
                end
                S_SEQ: state_q <= S_WAIT;
                S_WAIT: begin
                    if (cycDone) begin
                        if (stepIsRead(curOp_q, step_q))
                            rdata_q <= cycRdata;
                        if (step_q == lastStep(curOp_q)) begin
                            if (curOp_q == `FCS_OP_PROG || curOp_q == `FCS_OP_ERASE) begin
                                state_q <= S_POLL;
                            end else begin
                                if (curOp_q == `FCS_OP_AUTOSEL)
                                    autosel_q <= 1'b1;
                                if (curOp_q == `FCS_OP_RESET)
                                    autosel_q <= 1'b0;
                                busy_q  <= 1'b0;
                                done_q  <= 1'b1;
                                state_q <= S_IDLE;
                            end
                        end else begin
                            step_q  <= step_q + 3'd1;
                            state_q <= S_SEQ;
                        end
                    end
                end
                S_POLL: state_q <= S_PWAIT;
                S_PWAIT: begin
                    if (cycDone) begin
                        prev_q     <= cycRdata;
                        havePrev_q <= 1'b1;
                        rdata_q    <= cycRdata;
                        state_q    <= S_POLL;
                        // Embedded operation ends when toggling stops and ready-busy agrees
                        if (havePrev_q && (prev_q[`FCS_DQ_TOGGLE] == cycRdata[`FCS_DQ_TOGGLE]) && readyBusyIn) begin
                            busy_q  <= 1'b0;
                            done_q  <= 1'b1;
                            state_q <= S_IDLE;
                            // A 1 asked over a 0 reads back 0; flag the mismatch
                            if (curOp_q == `FCS_OP_PROG && cycRdata != wdata_q)
                                verifyErr_q <= 1'b1;
                        end else if (havePrev_q && cycRdata[`FCS_DQ_TIMEOUT]) begin
                            // Flag may rise just as the operation ends; confirm once
                            if (timeoutSeen_q) begin
                                err_q   <= 1'b1;
                                curOp_q <= `FCS_OP_RESET;
                                step_q  <= 3'd0;
                                state_q <= S_SEQ;
                            end
                            timeoutSeen_q <= 1'b1;
                        end
                    end
                end
                S_HWRST: begin
                    if (cnt_q <= 5'd1) begin
                        flashResetN <= 1'b1;
                        cnt_q       <= `FCS_T_RH_CYC;
                        state_q     <= S_HWWAIT;
                    end else begin
                        cnt_q <= cnt_q - 5'd1;
                    end
                end
                S_HWWAIT: begin
                    if (cnt_q <= 5'd1) begin
                        autosel_q <= 1'b0;
                        busy_q    <= 1'b0;
                        done_q    <= 1'b1;
                        state_q   <= S_IDLE;
                    end else begin
                        cnt_q <= cnt_q - 5'd1;
                    end
                end
                default: state_q <= S_IDLE;
            endcase
        end
    end
endmodule

// *** sim/fcs_flash_model.sv ***
// Behavioural flash device on the controller's far side
`timescale 1ns/10ps
`include "fcs_consts.vh"
module fcs_flash_model #(
    parameter [15:0] MAKER_ID = 16'h00c3, // Arbitrary value
    parameter [15:0] DEV_ID   = 16'h5a5a  // Arbitrary value
) (
    input  logic        ceN,
    input  logic        weN,
    input  logic        oeN,
    input  logic        byteN,
    input  logic        rstN,
    input  logic [17:0] addr,
    input  logic [15:0] dqIn,
    output logic [15:0] dqOut,
    output logic        rdyBusy
);
    logic [15:0] mem [16];
    logic [17:0] aL;
    logic [15:0] q = 16'h0;
    logic [2:0]  st = 3'h0;
    logic        pend = 0, busy = 0, fail = 0, auto = 0, tgl = 0;
    realtime     endT;
    wire  [17:0] u1 = byteN ? `FCS_UNLOCK1_ADDR_W : `FCS_UNLOCK1_ADDR_B;
    wire  [17:0] u2 = byteN ? `FCS_UNLOCK2_ADDR_W : `FCS_UNLOCK2_ADDR_B;
    wire  [7:0]  off = byteN ? addr[7:0] : {1'b0, addr[7:1]};
    assign rdyBusy = !busy;
    // Released bus shows the inverse, never a stale value
    assign dqOut = (!ceN && !oeN) ? q : ~q;
    initial foreach (mem[i]) mem[i] = 16'hffff;
    always #25 if (busy && !fail && $realtime >= endT) busy = 0;
    always @(negedge rstN) {st, busy, fail, auto, pend} = 0;
    always @(negedge weN or negedge ceN) if (!weN && !ceN && oeN) begin
        aL = addr;
        pend = rstN;
    end
    always @(negedge oeN) if (!ceN) begin
        tgl = !tgl;
        q = busy ? {9'h0, tgl, fail, 5'h0} : !auto ? mem[addr[3:0]] : off == 0 ? MAKER_ID
            : off == 1 ? DEV_ID : {15'h0, addr[17:12] == 0};
    end
    always @(posedge weN or posedge ceN) if (pend) begin
        pend = 0;
        if (dqIn[7:0] == 8'hf0 && (!busy || fail)) {st, busy, fail, auto} = 0;
        else if (!busy && !auto) case (st)
            0, 3: st = (aL == u1 && dqIn == `FCS_UNLOCK1_DATA) ? st + 3'h1 : 3'h0;
            1, 4: st = (aL == u2 && dqIn == `FCS_UNLOCK2_DATA) ? st + 3'h1 : 3'h0;
            2: begin
                auto = aL == u1 && dqIn == `FCS_CMD_AUTOSEL;
                st = aL != u1 ? 3'h0 : dqIn == `FCS_CMD_PROG ? 3'h6 : dqIn == `FCS_CMD_ERASE_SET ? 3'h3 : 3'h0;
            end
            5: begin
                if (aL == u1 && dqIn == `FCS_CMD_CHIP_ERASE) begin
                    foreach (mem[i]) mem[i] = 16'hffff;
                    busy = 1;
                    endT = $realtime + 3000;
                end
                st = 0;
            end
            default: begin
                fail = |(dqIn & ~mem[aL[3:0]]);
                mem[aL[3:0]] &= dqIn;
                busy = 1;
                endT = $realtime + 1000;
                st = 0;
            end
        endcase
    end
endmodule

// *** sim/fcs_host_ctrl_monitor.sv ***
// Pin timing checks of the flash host controller
`timescale 1ns/10ps
module fcs_host_ctrl_monitor (
    input logic        clk_sys,
    input logic        nrst,
    input logic        flashCeN,
    input logic        flashWeN,
    input logic        flashOeN,
    input logic [17:0] flashAddr,
    input logic [15:0] flashDqOut,
    input logic        flashDqOe,
    input logic        flashResetN
);
    logic [4:0] lowCnt_q;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    always @(posedge clk_sys) lowCnt_q <= flashResetN ? 5'h0 : lowCnt_q + 5'h1;
    sequence weStrobe; !flashWeN [*2] ##1 flashWeN; endsequence
    sequence ceRelease; !flashCeN ##1 flashCeN; endsequence
    a_write_qual: assert property (!flashWeN |-> !flashCeN && flashOeN && flashDqOe)
        else $error("strobe low without select");
    a_read_gate: assert property (!flashOeN |-> !flashCeN && flashWeN && !flashDqOe)
        else $error("gate low during write");
    a_strobe_width: assert property ($fell(flashWeN) |-> weStrobe)
        else $error("strobe width wrong");
    a_addr_setup: assert property ($fell(flashWeN) |-> $past(flashCeN) == 0 && $stable(flashAddr))
        else $error("select after strobe");
    a_data_hold: assert property (!flashWeN |=> $stable(flashDqOut) && $stable(flashAddr) && flashDqOe)
        else $error("data moved in strobe");
    a_ce_after: assert property ($rose(flashWeN) |-> ceRelease)
        else $error("select release wrong");
    a_reset_len: assert property ($rose(flashResetN) |-> lowCnt_q == 5'd20)
        else $error("reset pulse length wrong");
    a_quiet_reset: assert property (!flashResetN |-> flashWeN && flashCeN)
        else $error("access during reset");
endmodule
bind fcs_host_ctrl fcs_host_ctrl_monitor mon (.clk_sys, .nrst, .flashCeN, .flashWeN, .flashOeN,
    .flashAddr, .flashDqOut, .flashDqOe, .flashResetN);

// *** sim/tb_top.sv ***
// Self-checking bench for the flash host controller
`timescale 1ns/10ps
`include "fcs_consts.vh"
module tb_top;
    localparam [15:0] MAKER = 16'h00c3; // Arbitrary value
    localparam [15:0] DEVID = 16'h5a5a; // Arbitrary value
    typedef struct {logic [2:0] op; logic [17:0] a; logic [15:0] d; logic bm; logic [15:0] x; logic e;} fcs_row_t;
    logic        clk_sys = 0;
    logic        nrst = 0;
    logic [4:0]  avsAddress = 0;
    logic        avsRead = 0;
    logic        avsWrite = 0;
    logic [31:0] avsWriteData = 0;
    logic [3:0]  avsByteEnable = 4'hf;
    logic [31:0] avsReadData, rv;
    logic [17:0] flashAddr;
    logic [15:0] flashDqOut, memQ;
    logic        avsWaitRequest, flashCeN, flashWeN, flashOeN, flashDqOe, flashByteModeN, flashResetN, readyBusyIn;
    wire  [15:0] flashDqIn = flashDqOe ? flashDqOut : memQ;
    int          err_total = 0;
    int          checks_done = 0;
    fcs_row_t    rows [15] = '{'{2, 3, 16'h1234, 0, 0, 0}, '{1, 3, 0, 0, 16'h1234, 0},
        '{2, 3, 16'h5678, 0, 0, 1}, '{1, 3, 0, 0, 16'h1230, 0}, '{4, 0, 0, 0, MAKER, 0}, '{1, 1, 0, 0, DEVID, 0},
        '{1, 2, 0, 0, 1, 0}, '{1, 18'h1002, 0, 0, 0, 0}, '{5, 18'h2a5a5, 0, 0, 0, 0}, '{1, 3, 0, 0, 16'h1230, 0},
        '{3, 0, 0, 0, 0, 0}, '{1, 3, 0, 0, 16'hffff, 0}, '{4, 4, 0, 1, 1, 0}, '{6, 0, 0, 0, 0, 0},
        '{1, 3, 0, 0, 16'hffff, 0}};
    always #12.5 clk_sys = ~clk_sys;
    fcs_host_ctrl dut (.clk_sys, .nrst, .avsAddress, .avsRead, .avsWrite, .avsWriteData, .avsByteEnable,
        .avsReadData, .avsWaitRequest, .flashCeN, .flashWeN, .flashOeN, .flashAddr, .flashDqOut, .flashDqOe,
        .flashDqIn, .flashByteModeN, .flashResetN, .readyBusyIn);
    fcs_flash_model #(.MAKER_ID(MAKER), .DEV_ID(DEVID)) flash (.ceN(flashCeN), .weN(flashWeN), .oeN(flashOeN),
        .byteN(flashByteModeN), .rstN(flashResetN), .addr(flashAddr), .dqIn(flashDqOut), .dqOut(memQ),
        .rdyBusy(readyBusyIn));
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        avsAddress <= a;
        avsWriteData <= d;
        avsWrite <= w;
        avsRead <= !w;
        do @(posedge clk_sys); while (avsWaitRequest !== 1'b0);
        rv = avsReadData;
        avsWrite <= 0;
        avsRead <= 0;
    endtask
    task automatic idle;
        do bus(0, `FCS_REG_STATUS, 0); while (rv[`FCS_ST_BUSY] !== 1'b0);
    endtask
    task automatic cmp(input string s, input logic [31:0] x, input logic [31:0] v);
        checks_done++;
        if (v !== x) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", s, x, v);
        end
    endtask
    task automatic results;
        if (err_total == 0 && checks_done > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge clk_sys);
        nrst <= 1;
        cmp("pins", 5'b11101, {flashCeN, flashWeN, flashOeN, flashDqOe, flashResetN});
        bus(0, `FCS_REG_STATUS, 0);
        cmp("status", 32'h8, rv);
        foreach (rows[i]) begin
            bus(1, `FCS_REG_ADDR, rows[i].a);
            bus(1, `FCS_REG_WDATA, rows[i].d);
            bus(1, `FCS_REG_CTRL, {rows[i].bm, rows[i].op});
            idle();
            if (rows[i].op == 2) cmp("timeout", rows[i].e, rv[`FCS_ST_ERR]);
            bus(0, `FCS_REG_RDATA, 0);
            if (rows[i].op inside {1, 4}) cmp("rdata", rows[i].x, rv);
        end
        // Address write while programming must be refused
        bus(1, `FCS_REG_CTRL, 2);
        bus(1, `FCS_REG_ADDR, 7);
        bus(0, `FCS_REG_ADDR, 0);
        cmp("addr", 3, rv);
        idle();
        bus(1, `FCS_REG_CTRL, 1);
        idle();
        bus(0, `FCS_REG_RDATA, 0);
        cmp("rdata", 0, rv);
        bus(0, 5'h14, 0);
        cmp("unmapped", 0, rv);
        // Controller reset while idle after the read: sticky done must clear and pins return idle
        nrst <= 0;
        repeat (2) @(posedge clk_sys);
        nrst <= 1;
        cmp("pins", 5'b11101, {flashCeN, flashWeN, flashOeN, flashDqOe, flashResetN});
        bus(0, `FCS_REG_STATUS, 0);
        cmp("status", 32'h8, rv);
        results();
    end
    initial begin
        repeat (60000) @(posedge clk_sys);
        err_total++;
        results();
    end
endmodule
